// file: design/rtc_pit_pkg.sv
`default_nettype none
package rtc_pit_pkg;
  // ==========================================================
  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_CONTROL_A = 8'h00;
  localparam logic [7:0] IDX_SYNC_STATUS = 8'h01;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h02;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h03;
  localparam logic [7:0] IDX_TEMP = 8'h04;
  localparam logic [7:0] IDX_DEBUG_CONTROL = 8'h05;
  localparam logic [7:0] IDX_CLOCK_SELECT = 8'h07;
  localparam logic [7:0] IDX_COUNTER_VALUE = 8'h08;
  localparam logic [7:0] IDX_COUNTER_PERIOD = 8'h0a;
  localparam logic [7:0] IDX_COUNTER_COMPARE = 8'h0c;
  localparam logic [7:0] IDX_PERIODIC_CONTROL_A = 8'h10;
  localparam logic [7:0] IDX_PERIODIC_STATUS = 8'h11;
  localparam logic [7:0] IDX_PERIODIC_IRQ_ENABLE = 8'h12;
  localparam logic [7:0] IDX_PERIODIC_IRQ_FLAGS = 8'h13;
  localparam logic [7:0] IDX_PERIODIC_DEBUG_CONTROL = 8'h15;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 9;
  // ==========================================================
  // Field positions
  localparam int RTC_CONTROL_A_RUN_IN_STANDBY = 7;
  localparam int RTC_CONTROL_A_PRESC_MSB = 6;
  localparam int RTC_CONTROL_A_PRESC_LSB = 3;
  localparam int RTC_CONTROL_A_COUNTER_ENABLE = 0;
  localparam int PIT_PERIOD_MSB = 6;
  localparam int PIT_PERIOD_LSB = 3;
  localparam int PIT_ENABLE = 0;
  localparam int FLAG_OVERFLOW = 0;
  localparam int FLAG_COMPARE = 1;
  localparam int FLAG_PERIODIC = 0;
  // Write masks; unimplemented bits read as zero
  localparam logic [7:0] RTC_CONTROL_A_MASK = 8'hf9;
  localparam logic [7:0] PITCTRL_MASK = 8'h79;
  localparam logic [7:0] IRQ_MASK = 8'h03;
  localparam logic [7:0] BIT0_MASK = 8'h01;
  localparam logic [7:0] TIMER_CLOCK_SELECT_MASK = 8'h03;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] RESET_PERIOD = 16'hffff;
  // ==========================================================
  // Sync channels and timing
  localparam int SYNC_RTC_CONTROL_A = 0;
  localparam int SYNC_COUNT = 1;
  localparam int SYNC_PERIOD = 2;
  localparam int SYNC_COMPARE = 3;
  localparam int SYNC_PITCTRL = 4;
  localparam int SYNC_CHANNELS = 5;
  localparam logic [1:0] SYNC_TIMER_TICKS = 2'd2;
  localparam int PRESC_BITS = 15;
endpackage
`default_nettype wire

// file: design/rtc_pit_sync_and_control.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Counter keeps running while the system sits in idle sleep.
// - In standby the counter runs only if run-in-standby bit 7 is set.
// - Periodic timer runs in every sleep state regardless of run-in-standby.
// - Counter and periodic timer step on timer clock; writes cross with delay.
// - Status offset 0x01 shows compare, period, count, control A busy bits.
// - Periodic status offset 0x11 bit 0 busy while periodic control syncs.
// - Prescaler field 6:3 divides the timer clock by two to its power.
// - New control A setting applies two timer-clock cycles after the write.
// - Control A bit 0 enables the counter; zero disables it.
// - Shared prescaler clears when both enables are zero, else runs while either timer runs.
// - Writing one clears a compare or overflow flag; zero leaves it.
module rtc_pit_sync_and_control
  import rtc_pit_pkg::*;
#(
  // Timer ticks a synchronised write waits before it lands
  parameter int SYNC_TICKS = SYNC_TIMER_TICKS
)
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer clock pin and system state
  input wire logic timer_clock,
  input wire logic sleep_idle,
  input wire logic sleep_standby,
  input wire logic debug_halt,
  // Interrupt
  output logic irq
);
  // ==========================================================
  // Parameter check
  // The per-channel tick counter is two bits wide, so three ticks at most
  generate
    if (SYNC_TICKS < 1 || SYNC_TICKS > 3) begin : g_bad_sync_ticks
      $error("SYNC_TICKS must lie between 1 and 3");
    end
  endgenerate

  // ==========================================================
  // Timer clock sampling
  // Slow timer clock is sampled, so it must stay well below pclk / 4
  logic tclk_meta_r;
  logic tclk_sync_r;
  logic tclk_prev_r;
  logic timer_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tclk_meta_r <= 1'b0;
      tclk_sync_r <= 1'b0;
      tclk_prev_r <= 1'b0;
    end else begin
      tclk_meta_r <= timer_clock;
      tclk_sync_r <= tclk_meta_r;
      tclk_prev_r <= tclk_sync_r;
    end
  end

  assign timer_tick = tclk_sync_r & ~tclk_prev_r;

  // ==========================================================
  // APB decode
  logic [7:0] idx;
  logic setup;
  logic wr_en;
  logic hit;

  assign idx = paddr[ADDR_MSB:ADDR_LSB];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  always_comb begin
    case (idx)
      IDX_CONTROL_A, IDX_SYNC_STATUS, IDX_IRQ_ENABLE, IDX_IRQ_FLAGS,
      IDX_TEMP, IDX_DEBUG_CONTROL, IDX_CLOCK_SELECT, IDX_COUNTER_VALUE,
      IDX_COUNTER_PERIOD, IDX_COUNTER_COMPARE, IDX_PERIODIC_CONTROL_A,
      IDX_PERIODIC_STATUS, IDX_PERIODIC_IRQ_ENABLE, IDX_PERIODIC_IRQ_FLAGS,
      IDX_PERIODIC_DEBUG_CONTROL: hit = (paddr[1:0] == 2'b00);
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Software-side registers
  logic [7:0] rtc_control_a_r;
  logic [7:0] irq_en_r;
  logic [7:0] temp_r;
  logic [7:0] dbg_r;
  logic [7:0] timer_clock_select_r;
  logic [15:0] cnt_sh_r;
  logic [15:0] per_sh_r;
  logic [15:0] cmp_sh_r;
  logic [7:0] pitctrl_r;
  logic [7:0] pit_irq_en_r;
  logic [7:0] pit_dbg_r;

  // Control registers; their timer-side copies follow through the crossing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_control_a_r <= RESET_BYTE;
      pitctrl_r <= RESET_BYTE;
    end else if (wr_en) begin
      case (idx)
        IDX_CONTROL_A: rtc_control_a_r <= pwdata[7:0] & RTC_CONTROL_A_MASK;
        IDX_PERIODIC_CONTROL_A: pitctrl_r <= pwdata[7:0] & PITCTRL_MASK;
        default: rtc_control_a_r <= rtc_control_a_r;
      endcase
    end
  end

  // Interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= RESET_BYTE;
      pit_irq_en_r <= RESET_BYTE;
    end else if (wr_en) begin
      case (idx)
        IDX_IRQ_ENABLE: irq_en_r <= pwdata[7:0] & IRQ_MASK;
        IDX_PERIODIC_IRQ_ENABLE: pit_irq_en_r <= pwdata[7:0] & BIT0_MASK;
        default: irq_en_r <= irq_en_r;
      endcase
    end
  end

  // Count, period and compare shadows; count reads back the live counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_sh_r <= RESET_WORD;
      per_sh_r <= RESET_PERIOD;
      cmp_sh_r <= RESET_WORD;
    end else if (wr_en) begin
      case (idx)
        IDX_COUNTER_VALUE: cnt_sh_r <= pwdata[15:0];
        IDX_COUNTER_PERIOD: per_sh_r <= pwdata[15:0];
        IDX_COUNTER_COMPARE: cmp_sh_r <= pwdata[15:0];
        default: cnt_sh_r <= cnt_sh_r;
      endcase
    end
  end

  // Storage and debug bits; clock select drives nothing inside this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_r <= RESET_BYTE;
      dbg_r <= RESET_BYTE;
      timer_clock_select_r <= RESET_BYTE;
      pit_dbg_r <= RESET_BYTE;
    end else if (wr_en) begin
      case (idx)
        IDX_TEMP: temp_r <= pwdata[7:0];
        IDX_DEBUG_CONTROL: dbg_r <= pwdata[7:0] & BIT0_MASK;
        IDX_CLOCK_SELECT: timer_clock_select_r <= pwdata[7:0] & TIMER_CLOCK_SELECT_MASK;
        IDX_PERIODIC_DEBUG_CONTROL: pit_dbg_r <= pwdata[7:0] & BIT0_MASK;
        default: temp_r <= temp_r;
      endcase
    end
  end

  // ==========================================================
  // Write crossing: busy until two timer ticks have passed
  logic [SYNC_CHANNELS-1:0] sync_wr;
  logic [SYNC_CHANNELS-1:0] busy_r;
  logic [SYNC_CHANNELS-1:0] apply;

  assign sync_wr[SYNC_RTC_CONTROL_A] = wr_en & (idx == IDX_CONTROL_A);
  assign sync_wr[SYNC_COUNT] = wr_en & (idx == IDX_COUNTER_VALUE);
  assign sync_wr[SYNC_PERIOD] = wr_en & (idx == IDX_COUNTER_PERIOD);
  assign sync_wr[SYNC_COMPARE] = wr_en & (idx == IDX_COUNTER_COMPARE);
  assign sync_wr[SYNC_PITCTRL] = wr_en & (idx == IDX_PERIODIC_CONTROL_A);

  genvar g;
  generate
    for (g = 0; g < SYNC_CHANNELS; g = g + 1) begin : g_sync
      logic [1:0] ticks_r;
      assign apply[g] = busy_r[g] & timer_tick & (ticks_r == 2'(SYNC_TICKS - 1));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          busy_r[g] <= 1'b0;
          ticks_r <= 2'd0;
        end else if (sync_wr[g]) begin
          // A rewrite while busy restarts the crossing
          busy_r[g] <= 1'b1;
          ticks_r <= 2'd0;
        end else if (apply[g]) begin
          busy_r[g] <= 1'b0;
          ticks_r <= 2'd0;
        end else if (busy_r[g] && timer_tick) begin
          ticks_r <= ticks_r + 2'd1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Timer-side active copies
  logic [7:0] rtc_control_a_act_r;
  logic [7:0] pit_act_r;
  logic [15:0] per_act_r;
  logic [15:0] cmp_act_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_control_a_act_r <= RESET_BYTE;
      pit_act_r <= RESET_BYTE;
      per_act_r <= RESET_PERIOD;
      cmp_act_r <= RESET_WORD;
    end else begin
      if (apply[SYNC_RTC_CONTROL_A]) rtc_control_a_act_r <= rtc_control_a_r;
      if (apply[SYNC_PITCTRL]) pit_act_r <= pitctrl_r;
      if (apply[SYNC_PERIOD]) per_act_r <= per_sh_r;
      if (apply[SYNC_COMPARE]) cmp_act_r <= cmp_sh_r;
    end
  end

  // ==========================================================
  // Prescaler, counter and periodic timer
  logic cnt_en;
  logic pit_en;
  logic cnt_run;
  logic pit_run;
  logic [PRESC_BITS-1:0] presc_r;
  logic [15:0] cnt_r;
  logic [3:0] presc_sel;
  logic [3:0] pit_sel;
  logic [PRESC_BITS-1:0] div_mask;
  logic [PRESC_BITS-1:0] pit_mask;
  logic cnt_step;
  logic pit_event;
  logic ovf_event;
  logic cmp_event;

  assign cnt_en = rtc_control_a_act_r[RTC_CONTROL_A_COUNTER_ENABLE];
  assign pit_en = pit_act_r[PIT_ENABLE];
  assign presc_sel = rtc_control_a_act_r[RTC_CONTROL_A_PRESC_MSB:RTC_CONTROL_A_PRESC_LSB];
  assign pit_sel = pit_act_r[PIT_PERIOD_MSB:PIT_PERIOD_LSB];
  // Idle leaves the counter alone; standby needs run-in-standby
  assign cnt_run = cnt_en & ~(sleep_standby & ~rtc_control_a_act_r[RTC_CONTROL_A_RUN_IN_STANDBY])
                 & ~(debug_halt & ~dbg_r[0]);
  // Sleep state never gates the periodic timer
  assign pit_run = pit_en & ~(debug_halt & ~pit_dbg_r[0]);
  // Masks of low prescaler bits that must all be one: counter divides by 2^sel, periodic by 2^(sel+1)
  assign div_mask = PRESC_BITS'((16'h0001 << presc_sel) - 16'h0001);
  assign pit_mask = PRESC_BITS'((16'h0002 << pit_sel) - 16'h0001);
  assign cnt_step = timer_tick & cnt_run & ((presc_r & div_mask) == div_mask);
  assign pit_event = timer_tick & pit_run & (pit_sel != 4'h0) & (pit_sel != 4'hf)
                   & ((presc_r & pit_mask) == pit_mask);
  assign ovf_event = cnt_step & (cnt_r == per_act_r);
  assign cmp_event = cnt_step & (cnt_r == cmp_act_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= '0;
    end else if (!cnt_en && !pit_en) begin
      presc_r <= '0;
    end else if (timer_tick && (cnt_run || pit_run)) begin
      presc_r <= presc_r + PRESC_BITS'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= RESET_WORD;
    end else if (apply[SYNC_COUNT]) begin
      cnt_r <= cnt_sh_r;
    end else if (ovf_event) begin
      cnt_r <= RESET_WORD;
    end else if (cnt_step) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // ==========================================================
  // Interrupt flags, set wins over clear
  logic [1:0] flags_r;
  logic pit_flag_r;
  logic [1:0] flags_clr;
  logic pit_clr;

  assign flags_clr = (wr_en && idx == IDX_IRQ_FLAGS) ? pwdata[1:0] : 2'b00;
  assign pit_clr = wr_en & (idx == IDX_PERIODIC_IRQ_FLAGS) & pwdata[FLAG_PERIODIC];

  // Set wins, so an event in the clearing cycle is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= 2'b00;
    end else begin
      flags_r[FLAG_OVERFLOW] <= ovf_event
                              | (flags_r[FLAG_OVERFLOW] & ~flags_clr[FLAG_OVERFLOW]);
      flags_r[FLAG_COMPARE] <= cmp_event
                             | (flags_r[FLAG_COMPARE] & ~flags_clr[FLAG_COMPARE]);
    end
  end

  // Periodic flag, same write-one-to-clear behaviour
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pit_flag_r <= 1'b0;
    end else begin
      pit_flag_r <= pit_event | (pit_flag_r & ~pit_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_r & irq_en_r[1:0]) | (pit_flag_r & pit_irq_en_r[0]);
    end
  end

  // ==========================================================
  // Read mux and APB answer
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (idx)
      IDX_CONTROL_A: rd_val[7:0] = rtc_control_a_r;
      IDX_SYNC_STATUS: rd_val[3:0] = busy_r[3:0];
      IDX_IRQ_ENABLE: rd_val[7:0] = irq_en_r;
      IDX_IRQ_FLAGS: rd_val[1:0] = flags_r;
      IDX_TEMP: rd_val[7:0] = temp_r;
      IDX_DEBUG_CONTROL: rd_val[7:0] = dbg_r;
      IDX_CLOCK_SELECT: rd_val[7:0] = timer_clock_select_r;
      IDX_COUNTER_VALUE: rd_val[15:0] = cnt_r;
      IDX_COUNTER_PERIOD: rd_val[15:0] = per_sh_r;
      IDX_COUNTER_COMPARE: rd_val[15:0] = cmp_sh_r;
      IDX_PERIODIC_CONTROL_A: rd_val[7:0] = pitctrl_r;
      IDX_PERIODIC_STATUS: rd_val[0] = busy_r[SYNC_PITCTRL];
      IDX_PERIODIC_IRQ_ENABLE: rd_val[7:0] = pit_irq_en_r;
      IDX_PERIODIC_IRQ_FLAGS: rd_val[0] = pit_flag_r;
      IDX_PERIODIC_DEBUG_CONTROL: rd_val[7:0] = pit_dbg_r;
      default: rd_val = 32'h0000_0000;
    endcase
    if (!hit) begin
      rd_val = 32'h0000_0000;
    end
  end

  // One wait-free access phase; data captured during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= ~hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/rtc_pit_sync_and_control_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_pit_sync_and_control_checker
  import rtc_pit_pkg::*;
(
  // APB side of the block
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ==========================================
  // Helpers
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic setup;
  logic [7:0] idx;
  assign setup = psel && !penable;
  assign idx = paddr[9:2];

  // ==========================================
  // Bus answer
  chk_ready_after_setup: assert property (setup |=> pready)
    else $error("pready missing after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  chk_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on a write");

  // ==========================================
  // Holes and unimplemented bits
  chk_misaligned_err: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access accepted");
  chk_hole_err: assert property (setup && idx == 8'h06 |=> pslverr && prdata == 32'h0)
    else $error("reserved offset answered");
  chk_ctrl_clean: assert property (pready && !pwrite && idx == IDX_CONTROL_A |->
    prdata[2:1] == 2'h0 && prdata[31:8] == 24'h0)
    else $error("control a spare bits set");
  chk_status_upper: assert property (pready && !pwrite && idx == IDX_SYNC_STATUS |->
    prdata[31:4] == 28'h0)
    else $error("status spare bits set");

  // ==========================================
  // Busy seen right after the write; two timer ticks cannot pass this fast
  chk_ctrl_busy_seen: assert property (pready && pwrite && idx == IDX_CONTROL_A ##[1:2]
    (setup && !pwrite && idx == IDX_SYNC_STATUS) |=> prdata[0])
    else $error("control a busy not shown");
  chk_pit_busy_seen: assert property (pready && pwrite && idx == IDX_PERIODIC_CONTROL_A ##[1:2]
    (setup && !pwrite && idx == IDX_PERIODIC_STATUS) |=> prdata[0])
    else $error("periodic busy not shown");
endmodule
bind rtc_pit_sync_and_control rtc_pit_sync_and_control_checker u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr)
);
`default_nettype wire

// file: verification/rtc_pit_sync_and_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_pit_sync_and_control_tb import rtc_pit_pkg::*;;
  typedef struct {string nm; logic [31:0] exp; logic [31:0] slack; logic err;} note_type;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic timer_clock = 1'h0;
  logic sleep_idle = 1'h0;
  logic sleep_standby = 1'h0;
  int bad_count = 0;
  int checked = 0;
  logic [31:0] r;
  logic [31:0] d;
  note_type n;
  note_type q[$];
  logic [7:0] ridx[15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08,
    8'h0a, 8'h0c, 8'h10, 8'h11, 8'h12, 8'h13, 8'h15};
  logic [7:0] hole[4] = '{8'h06, 8'h09, 8'h0e, 8'h14};

  always #2 pclk = ~pclk;

  // Debug halt tied off: its registers are storage here
  rtc_pit_sync_and_control u_rtc_pit_sync_and_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_clock(timer_clock), .sleep_idle(sleep_idle), .sleep_standby(sleep_standby),
    .debug_halt(1'h0), .irq(irq));

  // ==========================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Gap cycle first, so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [7:0] i, input logic [1:0] lo,
    input logic [31:0] dat);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {22'h0, i, lo};
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] dat);
    apb(1'h1, i, 2'h0, dat);
  endtask

  // Slack absorbs the one-tick phase doubt of the crossing
  task automatic rd(input string nm, input logic [7:0] i, input logic [31:0] e,
    input logic [31:0] s = 0, input logic [1:0] lo = 0, input logic err = 0);
    q.push_back(note_type'{nm, e, s, err});
    apb(1'h0, i, lo, 32'h0);
  endtask

  // Each level lasts 4 pclk, above the 3 the synchroniser needs
  task automatic tick(input int k);
    repeat (k) begin
      timer_clock <= 1'h1;
      repeat (4) @(posedge pclk);
      timer_clock <= 1'h0;
      repeat (4) @(posedge pclk);
    end
  endtask

  // ==========================================
  // Read monitor
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (q.size() == 0) begin
        check("note queue", 32'h1, 32'h0);
      end else begin
        n = q.pop_front();
        d = prdata - n.exp;
        check(n.nm, (d <= n.slack) ? n.exp : prdata, n.exp);
        check({n.nm, " error"}, {31'h0, pslverr}, {31'h0, n.err});
      end
    end
  end

  initial begin
    #200000;
    check("watchdog", 32'h1, 32'h0);
    tally_and_finish;
  end

  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(87185));
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 15; i++) begin
      rd("reset value", ridx[i], (ridx[i] == 8'h0a) ? 32'h0000_ffff : 32'h0);
    end
    foreach (hole[i]) begin
      rd("reserved", hole[i], 32'h0, 0, 0, 1);
    end
    rd("misaligned", IDX_TEMP, 32'h0, 0, 2'h2, 1);
    r = $urandom;
    wr(IDX_TEMP, r);
    rd("temp", IDX_TEMP, {24'h0, r[7:0]});
    wr(IDX_CONTROL_A, 32'h7e);
    rd("busy", IDX_SYNC_STATUS, 32'h1);
    tick(1);
    rd("busy", IDX_SYNC_STATUS, 32'h1);
    tick(1);
    rd("busy", IDX_SYNC_STATUS, 32'h0);
    rd("control a", IDX_CONTROL_A, 32'h78);
    r = $urandom & 32'h3;
    wr(IDX_COUNTER_VALUE, r);
    wr(IDX_COUNTER_PERIOD, 32'h3);
    wr(IDX_COUNTER_COMPARE, 32'h2);
    rd("busy", IDX_SYNC_STATUS, 32'he);
    tick(2);
    rd("count", IDX_COUNTER_VALUE, r);
    sleep_idle <= 1'h1;
    wr(IDX_IRQ_ENABLE, 32'h1);
    wr(IDX_CONTROL_A, 32'h1);
    tick(10);
    rd("flags", IDX_IRQ_FLAGS, 32'h3);
    check("irq", {31'h0, irq}, 32'h1);
    wr(IDX_CONTROL_A, 32'h0);
    tick(2);
    wr(IDX_IRQ_FLAGS, 32'h0);
    rd("flags", IDX_IRQ_FLAGS, 32'h3);
    wr(IDX_IRQ_FLAGS, 32'h1);
    rd("flags", IDX_IRQ_FLAGS, 32'h2);
    check("masked irq", {31'h0, irq}, 32'h0);
    wr(IDX_IRQ_ENABLE, 32'h2);
    repeat (2) @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h1);
    wr(IDX_IRQ_FLAGS, 32'h2);
    repeat (2) @(posedge pclk);
    check("cleared irq", {31'h0, irq}, 32'h0);
    sleep_idle <= 1'h0;
    sleep_standby <= 1'h1;
    wr(IDX_COUNTER_VALUE, 32'h0);
    wr(IDX_CONTROL_A, 32'h1);
    tick(8);
    rd("standby count", IDX_COUNTER_VALUE, 32'h0);
    wr(IDX_CONTROL_A, 32'h81);
    tick(4);
    rd("standby count", IDX_COUNTER_VALUE, 32'h2, 32'h1);
    wr(IDX_PERIODIC_IRQ_ENABLE, 32'h1);
    wr(IDX_PERIODIC_CONTROL_A, 32'h9);
    rd("periodic busy", IDX_PERIODIC_STATUS, 32'h1);
    tick(2);
    rd("periodic busy", IDX_PERIODIC_STATUS, 32'h0);
    wr(IDX_CONTROL_A, 32'h0);
    tick(6);
    rd("periodic flag", IDX_PERIODIC_IRQ_FLAGS, 32'h1);
    sleep_standby <= 1'h0;
    wr(IDX_PERIODIC_CONTROL_A, 32'h0);
    wr(IDX_COUNTER_VALUE, 32'h0);
    wr(IDX_COUNTER_PERIOD, 32'h0000_ffff);
    wr(IDX_CONTROL_A, 32'h11);
    tick(10);
    rd("divided count", IDX_COUNTER_VALUE, 32'h2, 32'h1);
    repeat (4) @(posedge pclk);
    check("note queue", 32'(q.size()), 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
